/* File: include/eeprom_cmd_pkg.sv */
// Purpose: Shared constants and types of the serial EEPROM command port
// Assumes: 100 MHz core clock; serial pins arrive asynchronously
// Notes:   Times are kept in ns, cycle counts are derived from them
package eeprom_cmd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  // Least chip select low time before status may be shown (rounded up)
  localparam int CSL_MIN_NS = 250;
  localparam int CSL_MIN_CYCLES = (CSL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Self-timed programming cycle (longest time, rounded down)
  localparam int PROG_TIME_NS = 6000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Frame layout, counted in bits after the start marker bit
  localparam logic [4:0] HDR_BITS_X16 = 5'h0a;
  localparam logic [4:0] HDR_BITS_X8 = 5'h0b;
  localparam logic [4:0] DATA_BITS_X16 = 5'h10;
  localparam logic [4:0] DATA_BITS_X8 = 5'h08;

  // ==========================================================================
  // Opcodes and extended command selects
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRALL = 2'h1;
  localparam logic [1:0] EXT_ERALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;

  // ==========================================================================
  // Array
  localparam int ARRAY_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] LAST_BYTE = 8'hff;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_READ, ST_WAIT} frame_state_t;

  typedef struct packed {
    logic [1:0] op;
    logic [1:0] ext;
    logic x16;
    logic [7:0] addr;
    logic [15:0] data;
  } prog_req_t;

endpackage

/* File: hw/serial_eeprom_command_port.sv */
// Purpose: Three-wire serial command front end of a 2 Kbit EEPROM
// Assumes: Pins are asynchronous and pass two flip-flops; serial clock is
//          sampled by core_clk and its rising edges are found by comparison
// Notes:   Array contents are undefined until erased or written
//
// What this block does
// (R1) Start is the first serial clock rise with select and data both high.
// (R2) Before a start, no pin combination causes any operation.
// (R3) An instruction runs only after all its bits are shifted in.
// (R4) Wide words: start, opcode, spare bit, seven address bits, sixteen data bits.
// (R5) Narrow words: start, opcode, spare bit, eight address bits, eight data bits.
// (R6) Opcode 11 erases, 01 writes, 10 reads, 00 selects extended commands.
// (R7) Extended group: 10 erase all, 00 disable, 11 enable, 01 write all.
// (R8) Word size select high picks 16-bit words, low picks 8-bit.
// (R9) Input bits are taken on the rising serial clock edge.
// (R10) Data out floats unless reading or showing status.
// (R11) Status drives low while busy, high when ready.
// (R12) Every chip select fall floats data out.
// (R13) Standby ends as soon as chip select rises.
// (R14) Master keeps clock or data low while raising chip select.
// (R15) Power-up is program-disabled; erase and write are refused until enabled.
// (R16) Single erase sets every bit of the addressed word to one.
// (R17) Erase starts on chip select fall, or last address bit on fast variant.
// (R18) Status appears only after chip select low at least 250 ns.
// (R19) After completion, start bit then chip select fall clears status.
// (R20) Erase all sets the whole array to one in a self-timed cycle.
// (R21) Erase all completes with no further serial clock edges.
// (R22) A read drives a zero bit right before the data word.
// (R23) Programming stays enabled until a disable command.
// (R24) Holding chip select high keeps reading consecutive words.
// (R25) Chip select low holds the serial control logic in reset.
// (R26) A started cycle completes regardless of chip select, then standby.
// (R27) Each self-timed cycle is timed by a counter and reports busy.
`timescale 1ns/100ps

module serial_eeprom_command_port #(
  parameter int PROG_CYCLES_P = eeprom_cmd_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_din,
  output logic serial_dout,
  output logic serial_dout_oe,
  // Variant straps
  input wire logic word_size_select,
  input wire logic fast_start,
  // Status
  output logic busy,
  output logic program_enabled,
  output logic standby
);

  // ==========================================================================
  // Declarations
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic cs_s, clk_s, di_s, x16_s, fast_s;
  logic clk_rise, cs_fall, cs_rise, start_seen;
  eeprom_cmd_pkg::frame_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d, cnt_inc, hdr_len, data_len, frame_len;
  logic [26:0] sh_q, sh_d, sh_next;
  logic hdr_exec, data_exec, rd_start;
  eeprom_cmd_pkg::prog_req_t hdr_req, req_q, data_req, arm_req, job_q, launch_req;
  logic hdr_is_erase, hdr_needs_data, arm_hdr, arm_data, launch_now, launch;
  logic pend_q, we_q;
  logic busy_q;
  logic [19:0] pcnt_q;
  logic sweep_on_q;
  logic [7:0] sweep_q, sweep_last_q, sweep_first, sweep_last, fill_byte;
  logic job_erase;
  logic [7:0] mem [eeprom_cmd_pkg::ARRAY_BYTES];
  logic fetch_on_q, push, pop, fifo_full, fifo_valid;
  logic [7:0] fetch_addr_q, fetch_next;
  logic [15:0] fetch_word, fifo_head;
  logic [15:0] fifo_q [2];
  logic wp_q, rp_q;
  logic [1:0] fcnt_q;
  logic rd_on_q, out_bit_q, rd_shift, need_word;
  logic [15:0] out_sh_q;
  logic [4:0] bits_left_q;
  logic [5:0] low_cnt_q;
  logic low_long;
  logic status_pend_q, status_show_q, clear_arm_q;
  logic sdo_q, sdo_oe_q, standby_q;

  // Header decode shared by every instruction kind
  function automatic eeprom_cmd_pkg::prog_req_t decode_header(
    input logic [26:0] bits,
    input logic wide
  );
    eeprom_cmd_pkg::prog_req_t r;
    r.x16 = wide;
    r.data = 16'h0000;
    if (wide)
    begin
      r.op = bits[9:8];
      r.ext = bits[7:6];
      r.addr = {1'b0, bits[6:0]};
    end
    else
    begin
      r.op = bits[10:9];
      r.ext = bits[8:7];
      r.addr = bits[7:0];
    end
    return r;
  endfunction

  // ==========================================================================
  // Pin synchronisers and edge finding
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= 5'h00;
      pin_sync_q <= 5'h00;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= {fast_start, word_size_select, serial_din, serial_clk, chip_select};
      pin_sync_q <= pin_meta_q;
      sclk_prev_q <= clk_s;
      cs_prev_q <= cs_s;
    end
  end

  // Synchronised levels and their edges
  assign cs_s = pin_sync_q[0];
  assign clk_s = pin_sync_q[1];
  assign di_s = pin_sync_q[2];
  assign x16_s = pin_sync_q[3];
  assign fast_s = pin_sync_q[4];
  assign clk_rise = clk_s & ~sclk_prev_q; // R9
  assign cs_fall = ~cs_s & cs_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;
  assign start_seen = (state_q == eeprom_cmd_pkg::ST_IDLE) & cs_s & clk_rise & di_s; // R1

  // ==========================================================================
  // Frame framing and decode
  assign hdr_len = x16_s ? eeprom_cmd_pkg::HDR_BITS_X16 : eeprom_cmd_pkg::HDR_BITS_X8; // R8
  assign data_len = x16_s ? eeprom_cmd_pkg::DATA_BITS_X16 : eeprom_cmd_pkg::DATA_BITS_X8;
  assign frame_len = hdr_len + data_len; // R4 R5
  assign cnt_inc = cnt_q + 5'h01;
  assign sh_next = {sh_q[25:0], di_s};
  assign hdr_req = decode_header(sh_next, x16_s); // R6 R7
  assign hdr_is_erase = (hdr_req.op == eeprom_cmd_pkg::OP_ERASE) |
    ((hdr_req.op == eeprom_cmd_pkg::OP_EXT) & (hdr_req.ext == eeprom_cmd_pkg::EXT_ERALL));
  assign hdr_needs_data = (hdr_req.op == eeprom_cmd_pkg::OP_WRITE) |
    ((hdr_req.op == eeprom_cmd_pkg::OP_EXT) & (hdr_req.ext == eeprom_cmd_pkg::EXT_WRALL));

  // Next frame state; select low forces the idle state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    hdr_exec = 1'b0;
    data_exec = 1'b0;
    rd_start = 1'b0;
    if (!cs_s)
    begin
      state_d = eeprom_cmd_pkg::ST_IDLE; // R25
      cnt_d = 5'h00;
    end
    else if (clk_rise)
    begin
      case (state_q)
        eeprom_cmd_pkg::ST_IDLE:
        begin
          if (di_s)
          begin
            state_d = eeprom_cmd_pkg::ST_SHIFT; // R1 R2
            cnt_d = 5'h00;
          end
        end
        eeprom_cmd_pkg::ST_SHIFT:
        begin
          sh_d = sh_next;
          cnt_d = cnt_inc;
          if (cnt_inc == hdr_len)
          begin
            hdr_exec = 1'b1; // R3
            if (hdr_req.op == eeprom_cmd_pkg::OP_READ)
            begin
              rd_start = 1'b1;
              state_d = eeprom_cmd_pkg::ST_READ;
            end
            else if (!hdr_needs_data)
              state_d = eeprom_cmd_pkg::ST_WAIT;
          end
          else if (cnt_inc == frame_len)
          begin
            data_exec = 1'b1; // R3
            state_d = eeprom_cmd_pkg::ST_WAIT;
          end
        end
        eeprom_cmd_pkg::ST_READ, eeprom_cmd_pkg::ST_WAIT: ;
        default: state_d = eeprom_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Frame registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= eeprom_cmd_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 27'h0000000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  // ==========================================================================
  // Command arming, protection and launch
  always_comb
  begin
    data_req = req_q;
    data_req.data = req_q.x16 ? sh_next[15:0] : {8'h00, sh_next[7:0]};
  end
  assign arm_hdr = hdr_exec & hdr_is_erase;
  assign arm_data = data_exec;
  assign arm_req = hdr_exec ? hdr_req : data_req;
  assign launch_now = (arm_hdr | arm_data) & fast_s; // R17
  assign launch = (launch_now | (pend_q & cs_fall)) & we_q & ~busy_q; // R15 R17 R20

  // Pending command and program enable
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      req_q <= '0;
      pend_q <= 1'b0;
      we_q <= 1'b0; // R15
    end
    else
    begin
      if (hdr_exec | data_exec)
        req_q <= arm_req;
      pend_q <= cs_s & (((arm_hdr | arm_data) & ~fast_s) | pend_q);
      if (hdr_exec & (hdr_req.op == eeprom_cmd_pkg::OP_EXT) &
          (hdr_req.ext == eeprom_cmd_pkg::EXT_ENABLE))
        we_q <= 1'b1; // R23
      else if (hdr_exec & (hdr_req.op == eeprom_cmd_pkg::OP_EXT) &
               (hdr_req.ext == eeprom_cmd_pkg::EXT_DISABLE))
        we_q <= 1'b0; // R23
    end
  end

  // ==========================================================================
  // Self-timed programming engine
  // Request that the launch takes: fresh on the fast variant, else pending
  assign launch_req = launch_now ? arm_req : req_q;
  assign sweep_first = arm_req_whole(launch_req) ? 8'h00 :
    (launch_req.x16 ? {launch_req.addr[6:0], 1'b0} : launch_req.addr);
  assign sweep_last = arm_req_whole(launch_req) ? eeprom_cmd_pkg::LAST_BYTE :
    (launch_req.x16 ? {launch_req.addr[6:0], 1'b1} : launch_req.addr);
  // Only erase opcodes fill with ones; address bits of a single erase may mimic a select
  assign job_erase = (job_q.op == eeprom_cmd_pkg::OP_ERASE) |
    ((job_q.op == eeprom_cmd_pkg::OP_EXT) & (job_q.ext == eeprom_cmd_pkg::EXT_ERALL));
  assign fill_byte = job_erase ? eeprom_cmd_pkg::ERASED_BYTE : // R16 R20
    ((job_q.x16 & sweep_q[0]) ? job_q.data[15:8] : job_q.data[7:0]);

  // Whole-array commands sweep every byte
  function automatic logic arm_req_whole(input eeprom_cmd_pkg::prog_req_t r);
    return r.op == eeprom_cmd_pkg::OP_EXT;
  endfunction

  // Busy counter and byte sweep run without serial clock edges
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      pcnt_q <= 20'h00000;
      job_q <= '0;
      sweep_on_q <= 1'b0;
      sweep_q <= 8'h00;
      sweep_last_q <= 8'h00;
    end
    else if (launch)
    begin
      busy_q <= 1'b1; // R27
      pcnt_q <= 20'(PROG_CYCLES_P - 1);
      job_q <= launch_req;
      sweep_on_q <= 1'b1;
      sweep_q <= sweep_first;
      sweep_last_q <= sweep_last;
    end
    else
    begin
      if (busy_q)
      begin
        busy_q <= (pcnt_q != 20'h00000); // R21 R26 R27
        pcnt_q <= pcnt_q - 20'h00001;
      end
      if (sweep_on_q)
      begin
        sweep_on_q <= (sweep_q != sweep_last_q);
        sweep_q <= sweep_q + 8'h01;
      end
    end
  end

  // Array write port
  always_ff @(posedge core_clk)
  begin
    if (sweep_on_q)
      mem[sweep_q] <= fill_byte; // R16 R20
  end

  // ==========================================================================
  // Read prefetch into the two-entry buffer
  assign fetch_word = fetch_addr_q[7] & x16_s ? 16'h0000 :
    (x16_s ? {mem[{fetch_addr_q[6:0], 1'b1}], mem[{fetch_addr_q[6:0], 1'b0}]}
           : {mem[fetch_addr_q], 8'h00});
  assign fetch_next = x16_s ? {1'b0, fetch_addr_q[6:0] + 7'h01} : fetch_addr_q + 8'h01;
  assign fifo_full = (fcnt_q == 2'h2);
  assign fifo_valid = (fcnt_q != 2'h0);
  assign fifo_head = fifo_q[rp_q];
  assign push = fetch_on_q & ~fifo_full;
  assign rd_shift = (state_q == eeprom_cmd_pkg::ST_READ) & cs_s & clk_rise;
  assign need_word = (bits_left_q == 5'h00);
  assign pop = rd_shift & need_word & fifo_valid;

  // Address walk and buffer pointers; the full buffer stalls the walk
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !cs_s)
    begin
      fetch_on_q <= 1'b0;
      fetch_addr_q <= 8'h00;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fcnt_q <= 2'h0;
    end
    else
    begin
      if (rd_start)
      begin
        fetch_on_q <= 1'b1;
        fetch_addr_q <= hdr_req.addr;
      end
      else if (push)
        fetch_addr_q <= fetch_next; // R24
      if (push)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Buffer storage
  always_ff @(posedge core_clk)
  begin
    if (push)
      fifo_q[wp_q] <= fetch_word;
  end

  // Output shifter: dummy zero first, then words MSB first
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !cs_s)
    begin
      rd_on_q <= 1'b0;
      out_bit_q <= 1'b0;
      out_sh_q <= 16'h0000;
      bits_left_q <= 5'h00;
    end
    else if (rd_start)
    begin
      rd_on_q <= 1'b1;
      out_bit_q <= 1'b0; // R22
      bits_left_q <= 5'h00;
    end
    else if (rd_shift)
    begin
      if (pop)
      begin
        out_bit_q <= fifo_head[15];
        out_sh_q <= {fifo_head[14:0], 1'b0};
        bits_left_q <= data_len - 5'h01; // R24
      end
      else if (!need_word)
      begin
        out_bit_q <= out_sh_q[15];
        out_sh_q <= {out_sh_q[14:0], 1'b0};
        bits_left_q <= bits_left_q - 5'h01;
      end
    end
  end

  // ==========================================================================
  // Ready/busy status window
  assign low_long = (low_cnt_q >= 6'(eeprom_cmd_pkg::CSL_MIN_CYCLES));

  // Select-low timer, status show and the clear sequence
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      low_cnt_q <= 6'h00;
      status_pend_q <= 1'b0;
      status_show_q <= 1'b0;
      clear_arm_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= cs_s ? 6'h00 : (low_long ? low_cnt_q : low_cnt_q + 6'h01);
      if (launch)
        status_pend_q <= 1'b1;
      else if (cs_fall & clear_arm_q)
        status_pend_q <= 1'b0; // R19
      clear_arm_q <= cs_s & (clear_arm_q | (start_seen & ~busy_q & status_pend_q));
      status_show_q <= cs_s & (status_show_q | (cs_rise & status_pend_q & low_long)); // R18
    end
  end

  // Pin and status outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      standby_q <= 1'b1;
    end
    else
    begin
      sdo_oe_q <= cs_s & (rd_on_q | status_show_q); // R10 R12
      sdo_q <= rd_on_q ? out_bit_q : ~busy_q; // R11
      standby_q <= ~cs_s & ~busy_q; // R13 R26
    end
  end

  assign serial_dout = sdo_q;
  assign serial_dout_oe = sdo_oe_q;
  assign busy = busy_q;
  assign program_enabled = we_q;
  assign standby = standby_q;

  // ==========================================================================
  // Checks
  a_start_cond: assert property ( // R1 R2
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == eeprom_cmd_pkg::ST_IDLE && state_d != eeprom_cmd_pkg::ST_IDLE)
      |-> (cs_s && di_s && clk_rise))
    else $error("Frame began without a start condition");

  a_frame_length: assert property ( // R3 R4 R5
    @(posedge core_clk) disable iff (!rst_n)
    data_exec |-> (cnt_q == frame_len - 5'h01) && (state_q == eeprom_cmd_pkg::ST_SHIFT))
    else $error("Data phase ended at the wrong bit count");

  a_prog_gate: assert property ( // R15
    @(posedge core_clk) disable iff (!rst_n)
    $rose(busy_q) |-> $past(we_q))
    else $error("Programming started while disabled");

  a_enable_hold: assert property ( // R23
    @(posedge core_clk) disable iff (!rst_n)
    (we_q && !(hdr_exec && hdr_req.op == eeprom_cmd_pkg::OP_EXT
      && hdr_req.ext == eeprom_cmd_pkg::EXT_DISABLE)) |=> we_q)
    else $error("Program enable lost without a disable command");

  a_busy_span: assert property ( // R26 R27
    @(posedge core_clk) disable iff (!rst_n)
    launch |=> busy_q [*8])
    else $error("Busy dropped early in a self-timed cycle");

  a_sweep_done: assert property ( // R20 R21
    @(posedge core_clk) disable iff (!rst_n)
    $fell(busy_q) |-> !sweep_on_q)
    else $error("Array sweep still running at end of busy");

  a_dummy_zero: assert property ( // R22
    @(posedge core_clk) disable iff (!rst_n)
    (rd_start ##1 cs_s) |=> (serial_dout_oe && !serial_dout))
    else $error("Read did not lead with a zero bit");

  a_cs_release: assert property ( // R12 R25
    @(posedge core_clk) disable iff (!rst_n)
    !cs_s |=> (!sdo_oe_q && !rd_on_q && state_q == eeprom_cmd_pkg::ST_IDLE))
    else $error("Output or control not released with select low");

  a_status_level: assert property ( // R11
    @(posedge core_clk) disable iff (!rst_n)
    (status_show_q && !rd_on_q) |=> (sdo_q == !$past(busy_q)))
    else $error("Status level does not follow busy");

  a_hiz_default: assert property ( // R10
    @(posedge core_clk) disable iff (!rst_n)
    (!rd_on_q && !status_show_q) |=> !sdo_oe_q)
    else $error("Data out driven outside read or status");

endmodule

/* File: tb/serial_master_model.sv */
// Purpose: Serial bus master that frames commands for the EEPROM port
// Assumes: Pins change only on falling core clock edges
// Notes:   Link clock period is 80 ns and it rests low between frames
`timescale 1ns/100ps

module serial_master_model (
  // Pacing clock
  input wire logic core_clk,
  // Serial pins
  output logic chip_select,
  output logic serial_clk,
  output logic serial_din,
  input wire logic serial_dout,
  input wire logic serial_dout_oe
);
  // ==========================================================================
  // Pin state
  logic [31:0] rx;
  // Data out as the master sees it; an undriven line reads as the inverse
  wire logic dout_seen = serial_dout_oe ? serial_dout : ~serial_dout;

  // Idle pins, deselected
  initial
  begin
    chip_select = 1'b0;
    serial_clk = 1'b0;
    serial_din = 1'b0;
    rx = 32'h0;
  end

  // Pace by falling edges so the port sees settled levels
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Select with the clock low so no false start forms
  task automatic sel(input logic v);
    wait_n(1);
    serial_clk = 1'b0;
    chip_select = v;
    if (!v)
      serial_din = ~serial_din;
    wait_n(30);
  endtask

  // Shift bits MSB first; sample data out before each rise and once after
  task automatic xfer(input logic [26:0] b, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_din = b[i];
      wait_n(4);
      rx = {rx[30:0], dout_seen};
      serial_clk = 1'b1;
      wait_n(4);
      serial_clk = 1'b0;
    end
    wait_n(4);
    rx = {rx[30:0], dout_seen};
  endtask
endmodule

/* File: tb/serial_eeprom_command_port_tb.sv */
// Purpose: Self-checking bench of the serial EEPROM command port
// Assumes: Short programming count so each cycle ends quickly
// Notes:   Array image in the bench gives all read expectations
`timescale 1ns/100ps

module serial_eeprom_command_port_tb;
  // ==========================================================================
  // Clock, straps and bookkeeping
  localparam int PROG_N = 400;
  localparam int LIMIT = 40000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic word_size_select = 1'b1;
  logic fast_start = 1'b0;
  wire logic chip_select, serial_clk, serial_din, serial_dout, serial_dout_oe;
  wire logic busy, program_enabled, standby;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'h5c45;
  logic [7:0] mem [256];
  logic [7:0] a;
  logic [15:0] d;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Port under test and its master
  serial_eeprom_command_port #(.PROG_CYCLES_P(PROG_N)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .chip_select(chip_select), .serial_clk(serial_clk), .serial_din(serial_din),
    .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
    .word_size_select(word_size_select), .fast_start(fast_start), .busy(busy),
    .program_enabled(program_enabled), .standby(standby));
  serial_master_model m (.core_clk(core_clk), .chip_select(chip_select),
    .serial_clk(serial_clk), .serial_din(serial_din), .serial_dout(serial_dout),
    .serial_dout_oe(serial_dout_oe));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  function automatic logic [15:0] expw(input logic [7:0] x);
    if (word_size_select)
      return {mem[{x[6:0], 1'b1}], mem[{x[6:0], 1'b0}]};
    return {8'h00, mem[x]};
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Select, then start bit, opcode, spare bit, address and optional data
  task automatic frame(input logic [1:0] op, input logic sp, input logic [7:0] x,
    input logic [15:0] dd, input int nd);
    m.sel(1'b1);
    m.xfer(word_size_select ? {16'h0, 1'b1, op, sp, x[6:0]} : {15'h0, 1'b1, op, sp, x},
      word_size_select ? 11 : 12);
    if (nd > 0)
      m.xfer({11'h0, dd}, nd);
  endtask

  task automatic ext(input logic [1:0] e, input logic [15:0] dd, input int nd);
    frame(eeprom_cmd_pkg::OP_EXT, e[1], word_size_select ? {1'b0, e[0], 6'h00} : {e[0], 7'h00},
      dd, nd);
    m.sel(1'b0);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < PROG_N + 100 && busy !== 1'b0; i++)
      m.wait_n(1);
    // Status output follows busy one core cycle later
    m.wait_n(2);
    chk("idle", 16'h0, {15'h0, busy});
  endtask

  // Read one word and the next one in the same frame
  task automatic rd(input logic [7:0] x);
    int dw;
    logic [15:0] mask;
    logic [15:0] w0;
    dw = word_size_select ? 16 : 8;
    mask = word_size_select ? 16'hffff : 16'h00ff;
    frame(eeprom_cmd_pkg::OP_READ, 1'b0, x, 16'h0, dw);
    chk("dummy", 16'h0, {15'h0, m.rx[dw]});
    w0 = m.rx[15:0] & mask;
    chk("word", expw(x), w0);
    m.xfer(27'h0, dw);
    chk("next", expw(x + 8'h01), m.rx[15:0] & mask);
    m.sel(1'b0);
  endtask

  task automatic wr(input logic [7:0] x, input logic [15:0] dd, input logic ok);
    frame(eeprom_cmd_pkg::OP_WRITE, 1'b0, x, dd, word_size_select ? 16 : 8);
    m.sel(1'b0);
    chk("busy", {15'h0, ok}, {15'h0, busy});
    wait_idle();
    if (ok && word_size_select)
      {mem[{x[6:0], 1'b1}], mem[{x[6:0], 1'b0}]} = dd;
    else if (ok)
      mem[x] = dd[7:0];
  endtask

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    m.wait_n(5);
    chk("standby", 16'h1, {15'h0, standby});
    chk("enabled", 16'h0, {15'h0, program_enabled});
    m.sel(1'b1);
    chk("standby", 16'h0, {15'h0, standby});
    m.xfer(27'h0, 9);
    chk("oe", 16'h0, {15'h0, serial_dout_oe});
    m.sel(1'b0);
    ext(eeprom_cmd_pkg::EXT_ERALL, 16'h0, 0);
    chk("busy", 16'h0, {15'h0, busy});
    $display("Test reset and protection done");
    ext(eeprom_cmd_pkg::EXT_ENABLE, 16'h0, 0);
    chk("enabled", 16'h1, {15'h0, program_enabled});
    ext(eeprom_cmd_pkg::EXT_ERALL, 16'h0, 0);
    chk("busy", 16'h1, {15'h0, busy});
    chk("oe", 16'h0, {15'h0, serial_dout_oe});
    m.sel(1'b1);
    chk("status", 16'h2, {14'h0, serial_dout_oe, serial_dout});
    wait_idle();
    chk("status", 16'h3, {14'h0, serial_dout_oe, serial_dout});
    m.xfer(27'h1, 1);
    m.sel(1'b0);
    chk("oe", 16'h0, {15'h0, serial_dout_oe});
    m.sel(1'b1);
    chk("oe", 16'h0, {15'h0, serial_dout_oe});
    m.sel(1'b0);
    for (int i = 0; i < 256; i++)
      mem[i] = 8'hff;
    rd(8'h10);
    ext(eeprom_cmd_pkg::EXT_WRALL, 16'ha53c, 16);
    chk("busy", 16'h1, {15'h0, busy});
    wait_idle();
    for (int i = 0; i < 256; i++)
      mem[i] = i[0] ? 8'ha5 : 8'h3c;
    $display("Test whole array done");
    for (int k = 0; k < 6; k++)
    begin
      word_size_select = (k < 3);
      rnd = lfsr(rnd);
      a = rnd[7:0];
      rnd = lfsr(rnd);
      d = rnd[15:0];
      if (k == 2)
        a = 8'h7f;
      wr(a, d, 1'b1);
      rd(a);
    end
    $display("Test write and read done");
    frame(eeprom_cmd_pkg::OP_ERASE, 1'b0, a, 16'h0, 0);
    m.sel(1'b0);
    chk("busy", 16'h1, {15'h0, busy});
    wait_idle();
    mem[a] = 8'hff;
    fast_start = 1'b1;
    frame(eeprom_cmd_pkg::OP_ERASE, 1'b0, a + 8'h01, 16'h0, 0);
    m.wait_n(4);
    chk("busy", 16'h1, {15'h0, busy});
    m.sel(1'b0);
    wait_idle();
    fast_start = 1'b0;
    mem[a + 8'h01] = 8'hff;
    rd(a);
    $display("Test erase done");
    frame(eeprom_cmd_pkg::OP_WRITE, 1'b0, a, 16'h0, 3);
    m.sel(1'b0);
    chk("busy", 16'h0, {15'h0, busy});
    ext(eeprom_cmd_pkg::EXT_DISABLE, 16'h0, 0);
    chk("enabled", 16'h0, {15'h0, program_enabled});
    wr(a, 16'h0012, 1'b0);
    rd(a);
    $display("Test disable done");
    end_of_test();
  end
endmodule
